//--- include/dog_home_params.svh
`ifndef DOG_HOME_PARAMS_SVH
`define DOG_HOME_PARAMS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define HOME_OFS_CTRL   8'h00
`define HOME_OFS_HSPD   8'h04
`define HOME_OFS_CSPD   8'h08
`define HOME_OFS_POS    8'h0C
`define HOME_OFS_STAT   8'h10
`define HOME_OFS_ISTAT  8'h14
`define HOME_OFS_IMASK  8'h18
`define HOME_OFS_OTHER  8'h1C
// ----------------------------------------
// Reset values and speed limits (Hz)
// ----------------------------------------
`define HOME_HSPD_RST   18'h0_C350
`define HOME_CSPD_RST   18'h0_03E8
`define HOME_SPD_MIN    18'h0_000A
`define HOME_SPD_MAX16  18'h0_7FFF
`define HOME_SPD_MAXB   18'h1_86A0
`define HOME_SPD_MAXA   18'h3_0D40
`define HOME_RAMP_STEP  18'h0_1388
// Half the clock rate in Hz, pulse toggle threshold
`define HOME_HALF_HZ    28'h5F5_E100
// ----------------------------------------
// Timing
// ----------------------------------------
`define HOME_CLK_PS     5000
`define HOME_TICK_US    1000
`define HOME_TICK_CYC   (`HOME_TICK_US * 1000000 / `HOME_CLK_PS)
`define HOME_CLEAR_MS   20
`define HOME_CLEAR_TICKS (`HOME_CLEAR_MS * 1000 / `HOME_TICK_US)
`endif

//--- include/dog_home_pkg.sv
package dog_home_pkg;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_FWD   = 3'b001,
		ST_BACK  = 3'b010,
		ST_STOP  = 3'b011,
		ST_CREEP = 3'b100,
		ST_ZERO  = 3'b101,
		ST_CLR   = 3'b110,
		ST_SCAN  = 3'b111
	} state_e;

	typedef struct packed {
		logic dog;
		logic zero;
		logic fwdLim;
		logic revLim;
	} pins_s;

	typedef struct packed {
		logic adapter;
		logic wide32;
		logic dogFast;
		logic revAssigned;
		logic fwdAssigned;
		logic clearEn;
		logic homeRev;
		logic cmd;
	} ctrl_s;
endpackage : dog_home_pkg

//--- src/dog_search_zero_return.sv
// Overview of operation
// - Dog search needs both limits assigned
// - Ahead of dog: fast, creep, zero stop
// - In dog: back out, then home again
// - Past dog: limit, back through, re-approach
// - Home limit on: back out, re-approach
// - Fast dog sampled per ms, else scan
// - Position cleared after homing stop
// - Zero phase stops pulses without ramp
// - Operands latched at command start
// - Command removed while moving: ramp stop, no done
// - Busy refuses other pulse instructions
// - Dog never found: stop, abnormal end
// - Sixteen-bit speeds 10 to 32767 Hz
// - Wide homing speed up to 200k/100k
// - Clear output 20 ms plus scan
//
// The register addresses and the address-and-strobe port were chosen for this implementation.
`include "dog_home_params.svh"
`timescale 1ns/1ps
`default_nettype none
module dog_search_zero_return #(
	parameter int TICK_CYCLES = `HOME_TICK_CYC,
	parameter int CLEAR_TICKS = `HOME_CLEAR_TICKS
) (
	input  wire logic                clk,
	input  wire logic                srst,
	input  wire logic [7:0]          addr,
	input  wire logic [31:0]         wdata,
	input  wire logic                wrStb,
	input  wire logic                rdStb,
	output logic [31:0]              rdata,
	input  wire dog_home_pkg::pins_s pinsRaw,
	input  wire logic                scanTick,
	output logic                     pulseOut,
	output logic                     dirOut,
	output logic                     clearOut,
	output logic                     busy,
	output logic                     irq
);
	import dog_home_pkg::*;

	localparam int TW = $clog2(TICK_CYCLES + 1);
	localparam int CW = $clog2(CLEAR_TICKS + 1);
	if (TICK_CYCLES < 2 || CLEAR_TICKS < 1) begin : g_badParam
		$error("tick or clear count too small");
	end

	function automatic logic [17:0] stepTo(logic [17:0] c,
	                                       logic [17:0] t);
		if (c < t)
			return (t - c > `HOME_RAMP_STEP) ? c + `HOME_RAMP_STEP : t;
		return (c - t > `HOME_RAMP_STEP) ? c - `HOME_RAMP_STEP : t;
	endfunction : stepTo

	function automatic logic inRange(logic [17:0] v, logic [17:0] hi);
		return v >= `HOME_SPD_MIN && v <= hi;
	endfunction : inRange

	// ----------------------------------------
	// Pin synchronisers and sampling
	// ----------------------------------------
	pins_s           pinMeta_reg;
	pins_s           pinSync_reg;
	logic [TW-1:0]   tickCnt_reg;
	logic            dogSmp_reg;
	logic            dogPrev_reg;
	logic            zeroPrev_reg;
	ctrl_s           ctrl_reg;

	wire tickNow  = tickCnt_reg == TW'(TICK_CYCLES - 1);

	always_ff @(posedge clk) begin
		if (srst) begin
			pinMeta_reg  <= '0;
			pinSync_reg  <= '0;
			tickCnt_reg  <= '0;
			dogSmp_reg   <= 1'b0;
			dogPrev_reg  <= 1'b0;
			zeroPrev_reg <= 1'b0;
		end else begin
			pinMeta_reg  <= pinsRaw;
			pinSync_reg  <= pinMeta_reg;
			tickCnt_reg  <= tickNow ? '0 : tickCnt_reg + 1'b1;
			dogPrev_reg  <= dogSmp_reg;
			zeroPrev_reg <= pinSync_reg.zero;
			if (ctrl_reg.dogFast ? tickNow : scanTick)
				dogSmp_reg <= pinSync_reg.dog;
		end
	end

	// Dog and zero edges assume nothing else consumes those pins
	wire dogRise  = dogSmp_reg & ~dogPrev_reg;
	wire dogFall  = ~dogSmp_reg & dogPrev_reg;
	wire zeroRise = pinSync_reg.zero & ~zeroPrev_reg;

	// ----------------------------------------
	// Software registers
	// ----------------------------------------
	logic [17:0]     hSpd_reg;
	logic [17:0]     cSpd_reg;
	logic [17:0]     hLat_reg;
	logic [17:0]     cLat_reg;
	logic            revLat_reg;
	logic            clrLat_reg;
	logic            cmdPrev_reg;
	logic [2:0]      iStat_reg;
	logic [2:0]      iMask_reg;
	logic            doneFlag_reg;
	logic            abortFlag_reg;

	wire wrCtrl  = wrStb && addr == `HOME_OFS_CTRL;
	wire wrHspd  = wrStb && addr == `HOME_OFS_HSPD;
	wire wrCspd  = wrStb && addr == `HOME_OFS_CSPD;
	wire wrMask  = wrStb && addr == `HOME_OFS_IMASK;
	wire wrOther = wrStb && addr == `HOME_OFS_OTHER;
	wire rdIstat = rdStb && addr == `HOME_OFS_ISTAT;

	wire cmdRise = ctrl_reg.cmd & ~cmdPrev_reg;
	wire cmdFall = ~ctrl_reg.cmd & cmdPrev_reg;

	// ----------------------------------------
	// Start checks
	// ----------------------------------------
	state_e          state_reg;
	state_e          state_next;
	wire [17:0] maxHome = !ctrl_reg.wide32 ? `HOME_SPD_MAX16 :
	                      ctrl_reg.adapter ? `HOME_SPD_MAXA :
	                                         `HOME_SPD_MAXB;
	wire speedOk  = inRange(hSpd_reg, maxHome) &&
	                inRange(cSpd_reg, `HOME_SPD_MAX16);
	wire limitsOk = ctrl_reg.fwdAssigned & ctrl_reg.revAssigned;
	wire startReq = cmdRise && state_reg == ST_IDLE;
	wire startBad = startReq && !(limitsOk && speedOk);
	wire refuse   = wrOther && busy;

	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl_reg    <= '0;
			hSpd_reg    <= `HOME_HSPD_RST;
			cSpd_reg    <= `HOME_CSPD_RST;
			iMask_reg   <= '0;
			cmdPrev_reg <= 1'b0;
		end else begin
			cmdPrev_reg <= ctrl_reg.cmd;
			if (wrCtrl)
				ctrl_reg <= ctrl_s'(wdata[7:0]);
			if (wrHspd)
				hSpd_reg <= wdata[17:0];
			if (wrCspd)
				cSpd_reg <= wdata[17:0];
			if (wrMask)
				iMask_reg <= wdata[2:0];
		end
	end

	// Later writes do not disturb a running search
	always_ff @(posedge clk) begin
		if (srst) begin
			hLat_reg   <= `HOME_HSPD_RST;
			cLat_reg   <= `HOME_CSPD_RST;
			revLat_reg <= 1'b0;
			clrLat_reg <= 1'b0;
		end else if (startReq) begin
			hLat_reg   <= hSpd_reg;
			cLat_reg   <= cSpd_reg;
			revLat_reg <= ctrl_reg.homeRev;
			clrLat_reg <= ctrl_reg.clearEn;
		end
	end

	// ----------------------------------------
	// Search sequencer
	// ----------------------------------------
	state_e          stopNext_reg;
	state_e          stopNext_next;
	logic [17:0]     tgt_reg;
	logic [17:0]     tgt_next;
	logic [17:0]     spd_reg;
	logic            back_reg;
	logic            back_next;
	logic            seen_reg;
	logic            seen_next;
	logic            revd_reg;
	logic            revd_next;
	logic            fail_reg;
	logic            fail_next;
	logic [CW-1:0]   clrCnt_reg;
	logic [CW-1:0]   clrCnt_next;
	logic            doneEvt;
	logic            abortEvt;
	logic            zeroStop;

	wire homeLim = revLat_reg ? pinSync_reg.revLim : pinSync_reg.fwdLim;
	wire farLim  = revLat_reg ? pinSync_reg.fwdLim : pinSync_reg.revLim;
	wire startHomeLim = ctrl_reg.homeRev ? pinSync_reg.revLim
	                                     : pinSync_reg.fwdLim;
	wire moving  = state_reg inside {ST_FWD, ST_BACK, ST_CREEP, ST_ZERO};
	// Latch not yet loaded on the start edge
	wire homeRevNow = startReq ? ctrl_reg.homeRev : revLat_reg;

	always_comb begin
		state_next    = state_reg;
		stopNext_next = stopNext_reg;
		tgt_next      = tgt_reg;
		back_next     = back_reg;
		seen_next     = seen_reg;
		revd_next     = revd_reg;
		fail_next     = fail_reg;
		clrCnt_next   = clrCnt_reg;
		doneEvt       = 1'b0;
		abortEvt      = startBad;
		zeroStop      = 1'b0;
		unique case (state_reg)
			ST_IDLE: begin
				if (startReq && !startBad) begin
					tgt_next  = hSpd_reg;
					fail_next = 1'b0;
					// Inside dog or on home limit: back out first
					back_next = startHomeLim || dogSmp_reg;
					seen_next = dogSmp_reg;
					revd_next = back_next;
					state_next = back_next ? ST_BACK : ST_FWD;
				end
			end
			ST_FWD: begin
				if (dogRise) begin
					tgt_next   = cLat_reg;
					state_next = ST_CREEP;
				end else if (homeLim) begin
					tgt_next      = '0;
					fail_next     = revd_reg;
					stopNext_next = revd_reg ? ST_IDLE : ST_BACK;
					state_next    = ST_STOP;
				end
			end
			ST_BACK: begin
				if (dogRise)
					seen_next = 1'b1;
				if (dogFall && seen_reg) begin
					tgt_next      = '0;
					stopNext_next = ST_FWD;
					state_next    = ST_STOP;
				end else if (farLim) begin
					tgt_next      = '0;
					fail_next     = 1'b1;
					stopNext_next = ST_IDLE;
					state_next    = ST_STOP;
				end
			end
			ST_STOP: begin
				if (spd_reg == '0) begin
					state_next = stopNext_reg;
					tgt_next   = hLat_reg;
					back_next  = stopNext_reg == ST_BACK;
					seen_next  = dogSmp_reg;
					revd_next  = revd_reg | back_next;
					abortEvt   = fail_reg;
				end
			end
			ST_CREEP: begin
				if (dogFall)
					state_next = ST_ZERO;
			end
			ST_ZERO: begin
				if (zeroRise) begin
					zeroStop    = 1'b1;
					// Keep zero speed through the clear phase
					tgt_next    = '0;
					clrCnt_next = '0;
					doneEvt     = !clrLat_reg;
					state_next  = clrLat_reg ? ST_CLR : ST_IDLE;
				end
			end
			ST_CLR: begin
				if (tickNow) begin
					clrCnt_next = clrCnt_reg + 1'b1;
					// First tick is partial, so count one more
					if (clrCnt_reg == CW'(CLEAR_TICKS))
						state_next = ST_SCAN;
				end
			end
			ST_SCAN: begin
				if (scanTick) begin
					doneEvt    = 1'b1;
					state_next = ST_IDLE;
				end
			end
		endcase
		if (cmdFall && (moving || state_reg == ST_STOP) && !zeroStop) begin
			tgt_next      = '0;
			// A limit stop under way keeps its abnormal end
			fail_next     = fail_reg && state_reg == ST_STOP;
			stopNext_next = ST_IDLE;
			state_next    = ST_STOP;
		end
	end

	// ----------------------------------------
	// Speed ramp and pulse generator
	// ----------------------------------------
	logic [27:0]     acc_reg;
	logic [31:0]     pos_reg;
	wire  [27:0]     accSum = acc_reg + {10'h000, spd_reg};
	wire             accWrap = accSum >= `HOME_HALF_HZ;
	wire             pulseRise = accWrap && !pulseOut && spd_reg != '0;
	wire             goRev = revLat_reg ^ back_reg;

	always_ff @(posedge clk) begin
		if (srst) begin
			state_reg    <= ST_IDLE;
			stopNext_reg <= ST_IDLE;
			tgt_reg      <= '0;
			back_reg     <= 1'b0;
			seen_reg     <= 1'b0;
			revd_reg     <= 1'b0;
			fail_reg     <= 1'b0;
			clrCnt_reg   <= '0;
		end else begin
			state_reg    <= state_next;
			stopNext_reg <= stopNext_next;
			tgt_reg      <= tgt_next;
			back_reg     <= back_next;
			seen_reg     <= seen_next;
			revd_reg     <= revd_next;
			fail_reg     <= fail_next;
			clrCnt_reg   <= clrCnt_next;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			spd_reg  <= '0;
			acc_reg  <= '0;
			pulseOut <= 1'b0;
			pos_reg  <= '0;
		end else begin
			if (zeroStop || state_reg == ST_IDLE)
				spd_reg <= '0;
			else if (tickNow)
				spd_reg <= stepTo(spd_reg, tgt_reg);
			acc_reg  <= accWrap ? accSum - `HOME_HALF_HZ : accSum;
			// Stopping mid-pulse would leave the line high
			if (zeroStop || spd_reg == '0)
				pulseOut <= 1'b0;
			else if (accWrap)
				pulseOut <= ~pulseOut;
			if (zeroStop)
				pos_reg <= '0;
			else if (pulseRise)
				pos_reg <= goRev ? pos_reg - 1 : pos_reg + 1;
		end
	end

	// ----------------------------------------
	// Flags, interrupts and outputs
	// ----------------------------------------
	wire [2:0] evts  = {refuse, abortEvt, doneEvt};
	wire [2:0] iNext = evts | (iStat_reg & ~{3{rdIstat}});
	logic [31:0]     rdMux;

	always_comb begin
		unique case (addr)
			`HOME_OFS_CTRL:  rdMux = {24'h00_0000, ctrl_reg};
			`HOME_OFS_HSPD:  rdMux = {14'h0000, hSpd_reg};
			`HOME_OFS_CSPD:  rdMux = {14'h0000, cSpd_reg};
			`HOME_OFS_POS:   rdMux = pos_reg;
			`HOME_OFS_STAT:  rdMux = {26'h000_0000, state_reg,
			                          abortFlag_reg, doneFlag_reg, busy};
			`HOME_OFS_ISTAT: rdMux = {29'h0000_0000, iStat_reg};
			`HOME_OFS_IMASK: rdMux = {29'h0000_0000, iMask_reg};
			default:         rdMux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			rdata         <= '0;
			iStat_reg     <= '0;
			irq           <= 1'b0;
			busy          <= 1'b0;
			dirOut        <= 1'b0;
			clearOut      <= 1'b0;
			doneFlag_reg  <= 1'b0;
			abortFlag_reg <= 1'b0;
		end else begin
			rdata         <= rdStb ? rdMux : '0;
			iStat_reg     <= iNext;
			irq           <= |(iNext & iMask_reg);
			busy          <= state_next != ST_IDLE;
			dirOut        <= ~(homeRevNow ^ back_next);
			clearOut      <= state_next inside {ST_CLR, ST_SCAN};
			doneFlag_reg  <= doneEvt | (doneFlag_reg & ~startReq);
			abortFlag_reg <= abortEvt | (abortFlag_reg & ~startReq);
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_zero_stop: assert property (@(posedge clk) disable iff (srst)
		state_reg == ST_ZERO && zeroRise |=> spd_reg == '0 && !pulseOut)
		else $error("zero phase did not stop pulses at once");
	chk_pos_clear: assert property (@(posedge clk) disable iff (srst)
		zeroStop |=> pos_reg == 32'h0000_0000)
		else $error("position not cleared after homing stop");
	chk_busy_hold: assert property (@(posedge clk) disable iff (srst)
		spd_reg != '0 || pulseOut |-> busy)
		else $error("pulses while not busy");
	chk_refuse_busy: assert property (@(posedge clk) disable iff (srst)
		wrOther && busy |=> iStat_reg[2])
		else $error("busy request not refused");
	chk_abort_nodone: assert property (@(posedge clk) disable iff (srst)
		cmdFall && moving && !zeroStop
		|=> state_reg == ST_STOP ##1 !doneFlag_reg)
		else $error("abort did not ramp stop");
	chk_limit_need: assert property (@(posedge clk) disable iff (srst)
		startReq && !limitsOk |=> state_reg == ST_IDLE && abortFlag_reg)
		else $error("start taken without both limits");
	chk_creep_range: assert property (@(posedge clk) disable iff (srst)
		startReq && cSpd_reg > `HOME_SPD_MAX16 |=> !busy)
		else $error("creep speed out of range accepted");
	chk_clear_hold: assert property (@(posedge clk) disable iff (srst)
		$rose(clearOut) |-> clearOut[*8] ##0 !doneFlag_reg)
		else $error("clear output too short");
	chk_clear_done: assert property (@(posedge clk) disable iff (srst)
		$fell(clearOut) |-> doneFlag_reg)
		else $error("clear output ended without done flag");
	chk_latch_keep: assert property (@(posedge clk) disable iff (srst)
		busy && !startReq |=> $stable(hLat_reg) && $stable(cLat_reg))
		else $error("operands changed while running");
	chk_dog_back: assert property (@(posedge clk) disable iff (srst)
		state_reg == ST_BACK && seen_reg && dogFall && !cmdFall
		|=> state_reg == ST_STOP && stopNext_reg == ST_FWD)
		else $error("no stop on leaving dog");
	chk_no_dog: assert property (@(posedge clk) disable iff (srst)
		state_reg == ST_BACK && farLim && !dogFall && !cmdFall
		|=> fail_reg)
		else $error("missing dog not flagged");
endmodule : dog_search_zero_return
`default_nettype wire

//--- tb/servo_axis_model.sv
`timescale 1ns/1ps
`default_nettype none
module servo_axis_model (
	input  wire logic                clk,
	input  wire logic                pulseOut,
	input  wire logic                dirOut,
	input  wire logic                loadEn,
	input  wire logic [15:0]         loadVal,
	input  wire logic                dogOn,
	output var  dog_home_pkg::pins_s pins,
	output var  logic [15:0]         position
);
	import dog_home_pkg::*;
	// ----------------------------------------
	// Axis travel, one count per pulse
	// ----------------------------------------
	logic pulsePrev = 1'b0;
	always_ff @(posedge clk) begin
		pulsePrev <= pulseOut;
		if (loadEn) begin
			position <= loadVal;
		end else if (pulseOut && !pulsePrev) begin
			position <= dirOut ? position + 16'h0001 : position - 16'h0001;
		end
	end
	// ----------------------------------------
	// Sensors
	// ----------------------------------------
	// Dog and zero pins feed nothing else
	assign pins.dog = dogOn && position >= 16'h0013 && position <= 16'h0015;
	// Zero mark every 4 pulses; first one past the dog is 24
	assign pins.zero = (position[1:0] == 2'b00);
	assign pins.fwdLim = (position >= 16'h001B);
	assign pins.revLim = (position <= 16'h000F);
endmodule : servo_axis_model
`default_nettype wire

//--- tb/tb_dog_search_zero_return.sv
`include "dog_home_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_dog_search_zero_return;
	import dog_home_pkg::*;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic        wrStb = 1'b0;
	logic        rdStb = 1'b0;
	logic        scanTick = 1'b0;
	logic        loadEn = 1'b1;
	logic [15:0] loadVal = 16'h0011;
	logic        dogOn = 1'b1;
	logic [31:0] rdata;
	pins_s       pins;
	logic        pulseOut, dirOut, clearOut, busy, irq;
	logic [15:0] position;
	int          num_errors = 0;
	int          comparisons = 0;
	int          scanCnt = 0;

	always #2.5 clk = ~clk;
	// Scan strobe every 50 cycles
	always @(posedge clk) begin
		scanCnt <= (scanCnt == 49) ? 0 : scanCnt + 1;
		scanTick <= (scanCnt == 49);
	end

	dog_search_zero_return #(.TICK_CYCLES(20), .CLEAR_TICKS(2)) u_dog_search_zero_return (
		.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wrStb(wrStb),
		.rdStb(rdStb), .rdata(rdata), .pinsRaw(pins), .scanTick(scanTick),
		.pulseOut(pulseOut), .dirOut(dirOut), .clearOut(clearOut),
		.busy(busy), .irq(irq));
	servo_axis_model u_servo_axis_model (
		.clk(clk), .pulseOut(pulseOut), .dirOut(dirOut), .loadEn(loadEn),
		.loadVal(loadVal), .dogOn(dogOn), .pins(pins), .position(position));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic checkVal(input logic [31:0] got, input logic [31:0] exp,
		input string msg);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : checkVal
	task automatic checkBit(input logic got, input logic exp, input string msg);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: %s got %b", $time, msg, got);
		end
	endtask : checkBit
	task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wrStb <= 1'b1;
		@(posedge clk);
		wrStb <= 1'b0;
	endtask : regWrite
	task automatic regRead(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rdStb <= 1'b1;
		@(posedge clk);
		rdStb <= 1'b0;
		#1;
		d = rdata;
	endtask : regRead
	task automatic waitBusy(input logic exp, input int limit);
		int n;
		n = 0;
		#1;
		while (busy !== exp && n < limit) begin
			@(posedge clk);
			#1;
			n++;
		end
		checkBit(busy, exp, "busy wait");
	endtask : waitBusy
	task automatic loadPos(input logic [15:0] p);
		@(posedge clk);
		loadVal <= p;
		loadEn <= 1'b1;
		@(posedge clk);
		loadEn <= 1'b0;
		// Slow dog is sampled per scan: let one scan see the new spot
		repeat (60) @(posedge clk);
	endtask : loadPos
	task automatic give_verdict();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : give_verdict

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic resetValues();
		logic [31:0] d;
		#1;
		checkBit(busy | irq | clearOut | pulseOut, 1'b0, "outputs at reset");
		regRead(`HOME_OFS_CTRL, d);
		checkVal(d, 32'h0000_0000, "ctrl reset");
		regRead(`HOME_OFS_HSPD, d);
		checkVal(d, {14'h0000, `HOME_HSPD_RST}, "homing speed reset");
		regRead(`HOME_OFS_CSPD, d);
		checkVal(d, {14'h0000, `HOME_CSPD_RST}, "creep speed reset");
		regRead(8'h20, d);
		checkVal(d, 32'h0000_0000, "unmapped read");
		regWrite(`HOME_OFS_POS, 32'h0000_1234);
		regRead(`HOME_OFS_POS, d);
		checkVal(d, 32'h0000_0000, "position is read only");
	endtask : resetValues
	// Refused starts: stay idle, abnormal end raised
	task automatic badStart(input logic [7:0] ctrl, input logic [31:0] hs,
		input logic [31:0] cs);
		logic [31:0] d;
		regWrite(`HOME_OFS_HSPD, hs);
		regWrite(`HOME_OFS_CSPD, cs);
		regWrite(`HOME_OFS_CTRL, {24'h00_0000, ctrl});
		repeat (4) @(posedge clk);
		#1;
		checkBit(busy, 1'b0, "refused start busy");
		regRead(`HOME_OFS_STAT, d);
		checkVal(d & 32'h0000_0007, 32'h0000_0004, "abort flag");
		regRead(`HOME_OFS_ISTAT, d);
		checkVal(d & 32'h0000_0002, 32'h0000_0002, "abnormal event");
		regWrite(`HOME_OFS_CTRL, 32'h0000_0000);
	endtask : badStart
	// Start, look at the first direction, then drop the command
	task automatic dirCheck(input logic [15:0] p, input logic [7:0] ctrl,
		input logic expDir);
		logic [31:0] d;
		loadPos(p);
		regWrite(`HOME_OFS_CTRL, {24'h00_0000, ctrl});
		waitBusy(1'b1, 10);
		repeat (200) @(posedge clk);
		#1;
		checkBit(dirOut, expDir, "start direction");
		regWrite(`HOME_OFS_CTRL, 32'h0000_0000);
		waitBusy(1'b0, 5000);
		regRead(`HOME_OFS_STAT, d);
		checkVal(d & 32'h0000_0007, 32'h0000_0000, "no done after drop");
		regRead(`HOME_OFS_ISTAT, d);
		checkVal(d & 32'h0000_0001, 32'h0000_0000, "no done event");
	endtask : dirCheck
	task automatic normalHoming();
		logic [31:0] d;
		int n;
		loadPos(16'h0011);
		regWrite(`HOME_OFS_HSPD, 32'h0003_0D40);
		regWrite(`HOME_OFS_CSPD, 32'h0000_7FFF);
		regWrite(`HOME_OFS_IMASK, 32'h0000_0004);
		regWrite(`HOME_OFS_CTRL, 32'h0000_00FD);
		waitBusy(1'b1, 10);
		checkBit(dirOut, 1'b1, "home direction");
		// Flipped direction must not reach the running search
		regWrite(`HOME_OFS_CTRL, 32'h0000_00FF);
		regWrite(`HOME_OFS_OTHER, 32'h0000_0001);
		repeat (3) @(posedge clk);
		#1;
		checkBit(irq, 1'b1, "refused request irq");
		regRead(`HOME_OFS_ISTAT, d);
		checkVal(d & 32'h0000_0004, 32'h0000_0004, "refused event");
		repeat (3) @(posedge clk);
		#1;
		checkBit(irq, 1'b0, "irq after read clear");
		n = 0;
		while (clearOut !== 1'b1 && n < 45000) begin
			@(posedge clk);
			#1;
			n++;
		end
		checkVal({16'h0000, position}, 32'h0000_0018, "stop point");
		checkBit(busy, 1'b1, "busy during clear");
		n = 0;
		while (clearOut === 1'b1 && n < 1000) begin
			@(posedge clk);
			#1;
			n++;
		end
		checkBit(n >= 41 && n <= 110, 1'b1, "clear hold length");
		checkBit(busy, 1'b0, "busy ends with clear");
		repeat (100) @(posedge clk);
		#1;
		checkVal({16'h0000, position}, 32'h0000_0018, "no drift after stop");
		checkBit(irq, 1'b0, "done event masked");
		regRead(`HOME_OFS_STAT, d);
		checkVal(d & 32'h0000_0007, 32'h0000_0002, "done flag");
		regRead(`HOME_OFS_POS, d);
		checkVal(d, 32'h0000_0000, "position cleared");
		regRead(`HOME_OFS_ISTAT, d);
		checkVal(d & 32'h0000_0001, 32'h0000_0001, "done event");
		regWrite(`HOME_OFS_CTRL, 32'h0000_0000);
	endtask : normalHoming
	task automatic noDogHoming();
		logic [31:0] d;
		@(posedge clk);
		dogOn <= 1'b0;
		loadPos(16'h0011);
		regWrite(`HOME_OFS_CTRL, 32'h0000_00F9);
		waitBusy(1'b1, 10);
		waitBusy(1'b0, 45000);
		regRead(`HOME_OFS_STAT, d);
		checkVal(d & 32'h0000_0007, 32'h0000_0004, "abnormal end");
		regRead(`HOME_OFS_ISTAT, d);
		checkVal(d & 32'h0000_0002, 32'h0000_0002, "abnormal event");
		regWrite(`HOME_OFS_CTRL, 32'h0000_0000);
		dogOn <= 1'b1;
	endtask : noDogHoming

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		loadEn <= 1'b0;
		resetValues();
		badStart(8'hE1, 32'h0003_0D40, 32'h0000_03E8);
		badStart(8'hF9, 32'h0000_0009, 32'h0000_03E8);
		badStart(8'hB9, 32'h0000_8000, 32'h0000_03E8);
		badStart(8'hF9, 32'h0003_0D40, 32'h0000_8000);
		badStart(8'h59, 32'h0001_86A1, 32'h0000_03E8);
		badStart(8'hF9, 32'h0003_0D41, 32'h0000_03E8);
		regWrite(`HOME_OFS_HSPD, 32'h0001_86A0);
		regWrite(`HOME_OFS_CSPD, 32'h0000_7FFF);
		dirCheck(16'h0011, 8'h59, 1'b1);
		dirCheck(16'h0014, 8'h59, 1'b0);
		dirCheck(16'h0017, 8'h59, 1'b1);
		dirCheck(16'h001B, 8'h59, 1'b0);
		dirCheck(16'h000F, 8'h5B, 1'b1);
		normalHoming();
		noDogHoming();
		give_verdict();
	end
	initial begin
		#450000;
		num_errors++;
		$display("wrong value at %0t: watchdog expired", $time);
		give_verdict();
	end
endmodule : tb_dog_search_zero_return
`default_nettype wire
